/* hdl/odsc_serial_ctrl.sv */
`default_nettype none
// Behaviour
// - enable pin high forces channel five/six on
// - channel five/six is pin OR command bit
// - floating enable pins read low externally
// - data out floats while select low
// - first eight bits out are fault latches
// - then input stream delayed eight clocks
// - bytes travel most significant bit first
// - sample on rising, shift on falling
// - clear faults only after valid frame
// - select active only after clock transition
// - select pulses of 50 ns filtered
// - floating select reads low externally
// - received byte loads command register
// - partial byte discarded, command unchanged
// - command bit n drives channel n+1
// - open checked off, short checked on
// - fault bit set per faulty channel
// - faults relatch after clear if present
// - fault latches accumulate until cleared
// - reset leaves fault latches empty
// - load fault qualified over 100 us
// - thermal fault qualified over 40 us
module odsc_serial_ctrl
  import odsc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       chip_select,
  input  wire logic       serial_clock,
  input  wire logic       serial_in,
  output logic            serial_out,
  output logic            serial_out_en,
  input  wire logic       direct_enable_input_a,
  input  wire logic       direct_enable_input_b,
  input  wire logic [7:0] open_load_detect,
  input  wire logic [7:0] short_load_detect,
  input  wire logic [7:0] over_temp_detect,
  output logic [7:0]      driver_channels,
  output logic [7:0]      channel_command_bits,
  output logic [7:0]      channel_fault_bits
);
  typedef enum logic [2:0] {
    STATE_IDLE  = 3'b001,
    STATE_ARMED = 3'b010,
    STATE_SHIFT = 3'b100
  } odsc_state_type;

  // two-stage synchronisers; first stage feeds only the second
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic [4:0] pins_async;
  assign pins_async = {chip_select, serial_clock, serial_in,
                       direct_enable_input_a, direct_enable_input_b};

  // open enable pins pulled low outside
  // open select pulled low; stages clear low
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
    end else begin
      sync_a <= pins_async;
      sync_b <= sync_a;
    end
  end

  logic cs_raw;
  logic sck;
  logic sdi;
  logic pin_a;
  logic pin_b;
  assign {cs_raw, sck, sdi, pin_a, pin_b} = sync_b;

  // glitch filter on select: level must hold before it is believed
  // costs two cycles of latency on every select edge
  logic [3:0] cs_cnt;
  logic [3:0] next_cs_cnt;
  logic       cs_filt;
  logic       next_cs_filt;
  logic       sck_q;

  always_comb begin
    next_cs_cnt = 4'h0;
    next_cs_filt = cs_filt;
    if (cs_raw != cs_filt) begin
      next_cs_cnt = cs_cnt + 4'h1;
      if (cs_cnt == 4'(CS_FILTER_CYCLES - 1)) begin
        next_cs_filt = cs_raw;
        next_cs_cnt = 4'h0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cs_cnt  <= 4'h0;
      cs_filt <= 1'b0;
      sck_q   <= 1'b0;
    end else begin
      cs_cnt  <= next_cs_cnt;
      cs_filt <= next_cs_filt;
      sck_q   <= sck;
    end
  end

  // clock and data share one synchroniser, so they stay aligned
  logic sck_rise;
  logic sck_fall;
  assign sck_rise = sck && !sck_q;
  assign sck_fall = !sck && sck_q;

  // serial engine state
  odsc_state_type state;
  odsc_state_type next_state;
  logic [7:0] in_shift;
  logic [7:0] next_in_shift;
  logic [7:0] out_shift;
  logic [7:0] next_out_shift;
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic       byte_seen;
  logic       next_byte_seen;
  logic [7:0] last_byte;
  logic [7:0] next_last_byte;
  logic       start_low;
  logic       next_start_low;
  logic       dout;
  logic       next_dout;
  logic [7:0] command;
  logic [7:0] next_command;
  logic [7:0] faults;
  logic [7:0] next_faults;
  logic       clear_faults;

  // qualified fault inputs, one filter per channel and kind
  logic [7:0] load_q;
  logic [7:0] open_q;
  logic [7:0] short_q;
  logic [7:0] therm_q;
  logic [7:0] open_cond;
  logic [7:0] short_cond;

  assign open_cond  = open_load_detect & ~driver_channels;
  assign short_cond = short_load_detect & driver_channels;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_qual
      odsc_fault_qual #(.CYCLES(LOAD_FAULT_CYCLES)) u_open (
        .clock     (clock),
        .rst_n     (rst_n),
        .cond      (open_cond[g]),
        .qualified (open_q[g])
      );
      odsc_fault_qual #(.CYCLES(LOAD_FAULT_CYCLES)) u_short (
        .clock     (clock),
        .rst_n     (rst_n),
        .cond      (short_cond[g]),
        .qualified (short_q[g])
      );
      odsc_fault_qual #(.CYCLES(THERM_FAULT_CYCLES)) u_therm (
        .clock     (clock),
        .rst_n     (rst_n),
        .cond      (over_temp_detect[g]),
        .qualified (therm_q[g])
      );
    end
  endgenerate
  assign load_q = open_q | short_q;

  // serial frame sequencing
  always_comb begin
    next_state     = state;
    next_in_shift  = in_shift;
    next_out_shift = out_shift;
    next_bit_cnt   = bit_cnt;
    next_byte_seen = byte_seen;
    next_last_byte = last_byte;
    next_start_low = start_low;
    next_dout      = dout;
    next_command   = command;
    clear_faults   = 1'b0;
    case (state)
      STATE_IDLE: begin
        if (cs_filt) begin
          next_out_shift = faults;
          next_dout      = faults[7];
          next_bit_cnt   = BIT_COUNT_RESET;
          next_byte_seen = 1'b0;
          next_start_low = !sck;
          next_state     = STATE_ARMED;
        end
      end
      // one body for both, so the first rise is sampled, not swallowed
      STATE_ARMED, STATE_SHIFT: begin
        // a link clock edge makes select active
        if (sck_rise || sck_fall) begin
          next_state = STATE_SHIFT;
        end
        if (sck_rise) begin
          next_in_shift = {in_shift[6:0], sdi};
          next_bit_cnt  = bit_cnt + 3'h1;
          if (bit_cnt == 3'(BYTE_BITS - 1)) begin
            next_last_byte = {in_shift[6:0], sdi};
            next_byte_seen = 1'b1;
          end
        end
        // eight bit delay line
        // a fall that only arms select moves no data
        if (sck_fall && state == STATE_SHIFT) begin
          next_out_shift = {out_shift[6:0], in_shift[0]};
          next_dout      = out_shift[6];
        end
        if (!cs_filt) begin
          next_state = STATE_IDLE;
          if (byte_seen && bit_cnt == BIT_COUNT_RESET) begin
            next_command = last_byte;
            clear_faults = !sck && start_low;
          end
        end
      end
      default: begin
        next_state = STATE_IDLE;
      end
    endcase
  end

  always_comb begin
    next_faults = faults;
    if (clear_faults) begin
      next_faults = FAULT_RESET;
    end
    // a fault still present at a clear latches again at once
    // set wins over clear
    next_faults = next_faults | load_q | therm_q;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state     <= STATE_IDLE;
      in_shift  <= 8'h00;
      out_shift <= 8'h00;
      bit_cnt   <= BIT_COUNT_RESET;
      byte_seen <= 1'b0;
      last_byte <= COMMAND_RESET;
      start_low <= 1'b0;
      dout      <= 1'b0;
      command   <= COMMAND_RESET;
      faults    <= FAULT_RESET;
    end else begin
      state     <= next_state;
      in_shift  <= next_in_shift;
      out_shift <= next_out_shift;
      bit_cnt   <= next_bit_cnt;
      byte_seen <= next_byte_seen;
      last_byte <= next_last_byte;
      start_low <= next_start_low;
      dout      <= next_dout;
      command   <= next_command;
      faults    <= next_faults;
    end
  end

  assign serial_out    = dout;
  assign serial_out_en = (state != STATE_IDLE);

  // channel outputs: command bit n steers channel n+1
  always_comb begin
    driver_channels = command;
    driver_channels[CHAN_A_INDEX] = command[CHAN_A_INDEX] | pin_a;
    driver_channels[CHAN_B_INDEX] = command[CHAN_B_INDEX] | pin_b;
  end

  assign channel_command_bits = command;
  assign channel_fault_bits   = faults;
endmodule : odsc_serial_ctrl
`default_nettype wire

/* hdl/odsc_pkg.sv */
`default_nettype none
package odsc_pkg;
  localparam int unsigned CLOCK_HZ = 20_000_000;
  // fault qualification times in microseconds
  localparam int unsigned LOAD_FAULT_MIN_US = 100;
  localparam int unsigned LOAD_FAULT_MAX_US = 300;
  localparam int unsigned THERM_FAULT_MIN_US = 40;
  localparam int unsigned THERM_FAULT_MAX_US = 50;
  // least times scale by the whole-MHz clock to cycles, no rounding up
  localparam int unsigned LOAD_FAULT_CYCLES =
    (LOAD_FAULT_MIN_US * (CLOCK_HZ / 1_000_000));
  localparam int unsigned THERM_FAULT_CYCLES =
    (THERM_FAULT_MIN_US * (CLOCK_HZ / 1_000_000));
  // select glitch filter: pulses of 50 ns or less are dropped
  localparam int unsigned CS_GLITCH_NS = 50;
  localparam int unsigned CS_FILTER_CYCLES =
    (CS_GLITCH_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000 + 1;
  localparam int unsigned BYTE_BITS = 8;
  localparam logic [7:0] COMMAND_RESET = 8'h00;
  localparam logic [7:0] FAULT_RESET = 8'h00;
  localparam logic [2:0] BIT_COUNT_RESET = 3'h0;
  localparam int unsigned CHAN_A_INDEX = 4;
  localparam int unsigned CHAN_B_INDEX = 5;
  localparam int unsigned QUAL_WIDTH = 13;
endpackage : odsc_pkg
`default_nettype wire

/* hdl/odsc_fault_qual.sv */
`default_nettype none
// one channel: a condition must persist for a cycle count before it reports
module odsc_fault_qual
  import odsc_pkg::*;
#(
  parameter int unsigned CYCLES = 2
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic cond,
  output logic      qualified
);
  logic [QUAL_WIDTH-1:0] count;
  logic [QUAL_WIDTH-1:0] next_count;
  localparam logic [QUAL_WIDTH-1:0] LIMIT = QUAL_WIDTH'(CYCLES - 1);

  // counter restarts whenever the condition drops out
  always_comb begin
    next_count = count;
    if (!cond) begin
      next_count = '0;
    end else if (count != LIMIT) begin
      next_count = count + QUAL_WIDTH'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign qualified = cond && (count == LIMIT);
endmodule : odsc_fault_qual
`default_nettype wire

/* verif/odsc_serial_ctrl_assertions.sv */
`default_nettype none
module odsc_serial_ctrl_assertions (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       chip_select,
  input wire logic       serial_out_en,
  input wire logic       direct_enable_input_a,
  input wire logic       direct_enable_input_b,
  input wire logic [7:0] open_load_detect,
  input wire logic [7:0] short_load_detect,
  input wire logic [7:0] over_temp_detect,
  input wire logic [7:0] driver_channels,
  input wire logic [7:0] channel_command_bits,
  input wire logic [7:0] channel_fault_bits
);
  timeunit 1ns;
  timeprecision 1ns;
  // one domain; windows of 8 cover the pin sync plus filter delay
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_pin_forces_on: assert property (
    direct_enable_input_a [*4] |=> driver_channels[4])
    else $error("pin high, channel off");
  a_pin_or_cmd: assert property (
    !direct_enable_input_b [*4] ##1 $stable(channel_command_bits)
    |-> driver_channels[5] == channel_command_bits[5])
    else $error("channel b not command");
  a_cmd_to_chan: assert property (
    $stable(channel_command_bits) |->
    {driver_channels[7:6], driver_channels[3:0]} ==
    {channel_command_bits[7:6], channel_command_bits[3:0]})
    else $error("channel not command");
  a_out_floats: assert property (
    !chip_select [*8] |-> !serial_out_en)
    else $error("output driven while idle");
  a_out_drives: assert property (
    chip_select [*8] |-> serial_out_en)
    else $error("output floats in frame");
  a_reset_clear: assert property (
    $rose(rst_n) |-> channel_fault_bits == 8'h00)
    else $error("faults after reset");
  a_fault_hold: assert property (
    chip_select [*8] |-> (channel_fault_bits &
    $past(channel_fault_bits)) == $past(channel_fault_bits))
    else $error("fault lost in frame");
  a_fault_cause: assert property (
    (channel_fault_bits & ~$past(channel_fault_bits) &
    ~$past(open_load_detect) & ~$past(short_load_detect) &
    ~$past(over_temp_detect)) == 8'h00)
    else $error("fault set without cause");
endmodule : odsc_serial_ctrl_assertions
bind odsc_serial_ctrl odsc_serial_ctrl_assertions
  odsc_serial_ctrl_assertions_i (.clock, .rst_n, .chip_select,
  .serial_out_en, .direct_enable_input_a, .direct_enable_input_b,
  .open_load_detect, .short_load_detect, .over_temp_detect,
  .driver_channels, .channel_command_bits, .channel_fault_bits);
`default_nettype wire

/* verif/odsc_master.sv */
`default_nettype none
module odsc_master (
  input  wire logic clock,
  input  wire logic serial_out,
  input  wire logic serial_out_en,
  output logic      chip_select,
  output logic      serial_clock,
  output logic      serial_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle: select low, link clock parked low
  initial begin
    chip_select = 1'b0;
    serial_clock = 1'b0;
    serial_in = 1'b0;
  end
  task automatic frame(input int n, input logic [23:0] d,
                       output logic [23:0] q);
    q = 24'h000000;
    @(posedge clock) chip_select <= 1'b1;
    repeat (8) @(posedge clock);
    for (int i = n - 1; i >= 0; i--) begin
      // 400 ns link clock: four system clocks per half
      serial_in <= d[i];
      repeat (4) @(posedge clock);
      q = {q[22:0], serial_out_en & serial_out};
      serial_clock <= 1'b1;
      repeat (4) @(posedge clock);
      serial_clock <= 1'b0;
    end
    repeat (8) @(posedge clock);
    chip_select <= 1'b0;
    serial_in <= ~serial_in; // released line must not look held
    repeat (40) @(posedge clock); // 2 us, above the 1 us reload gap
  endtask : frame
  // one-cycle select pulse, short enough to be filtered
  task automatic glitch;
    @(posedge clock) chip_select <= 1'b1;
    @(posedge clock) chip_select <= 1'b0;
    repeat (40) @(posedge clock);
  endtask : glitch
  // select held while the link clock stays parked
  task automatic idle_select(input int n);
    @(posedge clock) chip_select <= 1'b1;
    repeat (n) @(posedge clock);
    chip_select <= 1'b0;
    repeat (40) @(posedge clock);
  endtask : idle_select
endmodule : odsc_master
`default_nettype wire

/* verif/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        direct_enable_input_a = 1'b0;
  logic        direct_enable_input_b = 1'b0;
  logic [7:0]  open_load_detect = 8'h00;
  logic [7:0]  short_load_detect = 8'h00;
  logic [7:0]  over_temp_detect = 8'h00;
  logic        chip_select, serial_clock, serial_in, serial_out;
  logic        serial_out_en;
  logic [7:0]  driver_channels, channel_command_bits, channel_fault_bits;
  logic [23:0] q;
  int          mismatches = 0;
  int          n_compared = 0;
  // 20 MHz system clock
  always #25 clock = ~clock;
  odsc_serial_ctrl odsc_serial_ctrl_i (.clock, .rst_n, .chip_select,
    .serial_clock, .serial_in, .serial_out, .serial_out_en,
    .direct_enable_input_a, .direct_enable_input_b, .open_load_detect,
    .short_load_detect, .over_temp_detect, .driver_channels,
    .channel_command_bits, .channel_fault_bits);
  odsc_master odsc_master_i (.clock, .serial_out, .serial_out_en,
    .chip_select, .serial_clock, .serial_in);
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
  endtask : wait_clk
  task automatic check(input string name, input logic [23:0] exp,
                       input logic [23:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // command byte, daisy chain and a cut-short byte
  task automatic t_frames;
    check("fault", 24'h0, channel_fault_bits);
    odsc_master_i.frame(16, 24'h005aa5, q);
    check("daisy", 24'h00005a, q);
    check("command", 24'ha5, channel_command_bits);
    check("channels", 24'ha5, driver_channels);
    odsc_master_i.frame(12, 24'h000c3f, q);
    check("tail", 24'h00000c, q);
    check("command", 24'ha5, channel_command_bits);
  endtask : t_frames
  // latch, refuse clear, glitch, clear, relatch
  task automatic t_fault;
    open_load_detect <= 8'h06; // ch2 off counts, ch3 on ignored
    short_load_detect <= 8'h09; // ch1 on counts, ch4 off ignored
    over_temp_detect <= 8'h80;
    wait_clk(2100); // loads settle before faults are read
    check("fault", 24'h83, channel_fault_bits);
    open_load_detect <= 8'h00;
    short_load_detect <= 8'h00;
    over_temp_detect <= 8'h00;
    odsc_master_i.frame(12, 24'h000a5a, q);
    check("fault out", 24'h00083a, q);
    check("fault", 24'h83, channel_fault_bits);
    odsc_master_i.glitch();
    check("fault", 24'h83, channel_fault_bits);
    check("command", 24'ha5, channel_command_bits);
    odsc_master_i.idle_select(20);
    check("fault", 24'h83, channel_fault_bits);
    check("command", 24'ha5, channel_command_bits);
    over_temp_detect <= 8'h80;
    odsc_master_i.frame(8, 24'h000000, q);
    check("fault out", 24'h000083, q);
    check("fault", 24'h00, channel_fault_bits);
    check("command", 24'h00, channel_command_bits);
    wait_clk(900);
    check("fault", 24'h80, channel_fault_bits);
  endtask : t_fault
  // direct enables with command bits off
  task automatic t_pins;
    direct_enable_input_a <= 1'b1;
    direct_enable_input_b <= 1'b1;
    wait_clk(8);
    check("channels", 24'h30, driver_channels);
    direct_enable_input_a <= 1'b0;
    direct_enable_input_b <= 1'b0;
    wait_clk(8);
    check("channels", 24'h00, driver_channels);
  endtask : t_pins
  initial begin
    wait_clk(5);
    rst_n <= 1'b1;
    wait_clk(3);
    t_frames();
    t_fault();
    t_pins();
    give_verdict();
  end
endmodule : tb
`default_nettype wire
